// *** logic/hostport_defs.svh ***
// Purpose: Constants shared by both ends of the parallel host port
// Assumes: Included by package and modules
// Notes:   Guarded against double inclusion
`ifndef HOSTPORT_DEFS_SVH
`define HOSTPORT_DEFS_SVH
`define ADDR_W        16
`define DATA_W        16
`define PIN_ADDR_W    5
`define BYTE_HI_MSB   15
`define BYTE_HI_LSB   8
`define BYTE_LO_MSB   7
`define BYTE_LO_LSB   0
`define HOST_SETUP_CYC 4'h4
`define HOST_HOLD_CYC  4'h4
`endif

// *** logic/hostport_pkg.sv ***
// Purpose: Types for the parallel host port
// Assumes: hostport_defs.svh constants
// Notes:   Address mode and host state encodings, plus an unused struct
`include "hostport_defs.svh"
package hostport_pkg;
  typedef enum logic [1:0] {
    MODE_NONMUX  = 2'b00,
    MODE_MUX_ONE = 2'b01,
    MODE_MUX_TWO = 2'b10
  } addr_mode_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_ALE_A = 3'b001,
    H_ALE_B = 3'b010,
    H_DATA  = 3'b011,
    H_HOLD  = 3'b100
  } host_state_t;

  typedef struct packed {
    logic [3:0]  byte_en_dummy;
  } unused_t;
endpackage

// *** logic/parallel_host_port_if.sv ***
// Purpose: Pin bundle between host and device ends
// Assumes: Wire levels resolved by the testbench from the enables
// Notes:   Two-way bus split into in, out and enable per end
`timescale 1ns/1ps
interface parallel_host_port_if;
  logic        rd_n;
  logic        rd_wr;
  logic        wr_n;
  logic        data_phase_strobe;
  logic        cs_n;
  logic [4:0]  addr;
  logic        high_addr_latch;
  logic        low_addr_latch;
  logic [15:0] ad_host_out;
  logic [15:0] ad_host_oe;
  logic [15:0] ad_dev_out;
  logic [15:0] ad_dev_oe;
  logic [15:0] ad_in;

  modport device (input rd_n, rd_wr, wr_n, data_phase_strobe, cs_n, addr,
                  high_addr_latch, low_addr_latch, ad_in,
                  output ad_dev_out, ad_dev_oe);
  modport host (output rd_n, rd_wr, wr_n, data_phase_strobe, cs_n, addr,
                high_addr_latch, low_addr_latch, ad_host_out, ad_host_oe,
                input ad_in);
endinterface

// *** logic/host_port_device.sv ***
// Purpose: Device end of the parallel host port; turns pin strobes into
//          internal read and write requests
// Assumes: Host strobes are asynchronous; two-stage sync on every pin
// Notes:   Polarity and mode come from configuration inputs
// How it works
// RULE_01: Read strobe active low, polarity bit inverts.
// RULE_02: Direction high means read, polarity bit swaps.
// RULE_03: Enable with direction marks data phase.
// RULE_04: Write strobe polarity shares enable polarity bit.
// RULE_05: Chip select qualifies transfer, own polarity bit.
// RULE_06: Non-mux uses five address pins, 16-bit drops bit0.
// RULE_07: Non-mux 8-bit leaves upper data lines disabled.
// RULE_08: Single-phase mux takes both bytes at once.
// RULE_09: Dual-phase mux takes bytes on lower lines.
// RULE_10: Dual-phase 8-bit leaves upper lines disabled.
// RULE_11: High latch loads upper byte in dual-phase.
// RULE_12: Low latch loads both or lower byte.
// RULE_13: Latches active low, saved on rising edge.
// RULE_14: Deselected: ignore strobes, outputs high impedance.
// RULE_15: Drive data only during active read phase.
`timescale 1ns/1ps
`include "hostport_defs.svh"
module host_port_device
  import hostport_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Configuration
  input  wire logic [1:0]        addr_mode,
  input  wire logic              wide_data,
  input  wire logic              use_enable,
  input  wire logic              rd_pol_inv,
  input  wire logic              wr_pol_inv,
  input  wire logic              cs_pol_inv,
  input  wire logic              ale_pol_inv,
  // Pins
  parallel_host_port_if.device   pins,
  // Internal space
  output logic                   rd_req,
  output logic                   wr_req,
  output logic [`ADDR_W-1:0]     req_addr,
  output logic [`DATA_W-1:0]     wr_data,
  input  wire logic [`DATA_W-1:0] rd_data
);
  localparam int NS = 6;

  typedef struct packed {
    logic [NS-1:0]     s1;
    logic [NS-1:0]     s2;
    logic [NS-1:0]     prev;
    logic [15:0]       d1;
    logic [15:0]       d2;
    logic [15:0]       d3;
    logic [4:0]        a1;
    logic [4:0]        a2;
    logic              dir1;
    logic              dir2;
    logic [15:0]       addr;
    logic [15:0]       wdata;
    logic [15:0]       rdata;
    logic              drive;
    logic              rd_req;
    logic              wr_req;
    logic [1:0]        warm;
  } dev_state_t;

  dev_state_t st_r;
  dev_state_t st_nxt;

  // Index order of synchronised strobes
  localparam int I_CS = 0;
  localparam int I_RD = 1;
  localparam int I_WR = 2;
  localparam int I_EN = 3;
  localparam int I_HI = 4;
  localparam int I_LO = 5;

  logic [NS-1:0] raw;
  logic          ready;
  logic          sel;
  logic          rd_act;
  logic          wr_act;
  logic          en_act;
  logic          is_read;
  logic          hi_act;
  logic          lo_act;
  logic          hi_rise;
  logic          lo_rise;
  logic          rd_phase;
  logic          wr_end;
  logic          rd_end;
  logic [15:0]   ad_s;
  logic [15:0]   ad_hold;
  logic [15:0]   na_addr;
  addr_mode_t    mode;

  function automatic logic active_low(input logic lvl, input logic inv);
    active_low = inv ? lvl : ~lvl;
  endfunction

  assign raw = {pins.low_addr_latch, pins.high_addr_latch, pins.data_phase_strobe,
                pins.wr_n, pins.rd_n, pins.cs_n};
  assign mode = addr_mode_t'(addr_mode);
  assign ad_s = st_r.d2;
  // Last sample taken while a latch strobe was still active; the host
  // may move the lines at the strobe's trailing edge
  assign ad_hold = st_r.d3;

  // No strobe counts until the edge stage holds a real pin sample; with
  // inverted polarity the reset pattern would look like an active strobe
  assign ready   = (st_r.warm == 2'h3);
  assign sel     = ready && active_low(st_r.s2[I_CS], cs_pol_inv); // [RULE_05] [RULE_14]
  assign rd_act  = active_low(st_r.s2[I_RD], rd_pol_inv);        // [RULE_01]
  assign wr_act  = active_low(st_r.s2[I_WR], wr_pol_inv);        // [RULE_04]
  assign en_act  = active_low(st_r.s2[I_EN], wr_pol_inv);        // [RULE_03]
  // Direction has its own two-stage synchroniser, aligned with the strobes
  assign is_read = rd_pol_inv ? ~st_r.dir2 : st_r.dir2;          // [RULE_02]
  assign hi_act  = active_low(st_r.s2[I_HI], ale_pol_inv);       // [RULE_13]
  assign lo_act  = active_low(st_r.s2[I_LO], ale_pol_inv);
  // Active-to-inactive edge of a latch strobe saves the address
  assign hi_rise = sel && !hi_act && active_low(st_r.prev[I_HI], ale_pol_inv); // [RULE_13] [RULE_14]
  assign lo_rise = sel && !lo_act && active_low(st_r.prev[I_LO], ale_pol_inv); // [RULE_13] [RULE_14]

  // Read phase: RD strobe, or enable with direction read
  assign rd_phase = sel && (use_enable ? (en_act && is_read) : rd_act);  // [RULE_03] [RULE_14]
  assign rd_end   = use_enable ? (active_low(st_r.prev[I_EN], wr_pol_inv) && !en_act)
                               : (active_low(st_r.prev[I_RD], rd_pol_inv) && !rd_act);
  assign wr_end   = sel && (use_enable
                    ? (active_low(st_r.prev[I_EN], wr_pol_inv) && !en_act && !is_read)
                    : (active_low(st_r.prev[I_WR], wr_pol_inv) && !wr_act));

  // Non-mux address: 16-bit mode drops bit 0
  assign na_addr = wide_data ? {11'h000, st_r.a2[4:1], 1'b0}
                             : {11'h000, st_r.a2};                // [RULE_06]

  always_comb begin
    st_nxt        = st_r;
    st_nxt.s1     = raw;
    st_nxt.s2     = st_r.s1;
    st_nxt.prev   = st_r.s2;
    st_nxt.d1     = pins.ad_in;
    st_nxt.d2     = st_r.d1;
    st_nxt.d3     = st_r.d2;
    st_nxt.a1     = pins.addr;
    st_nxt.a2     = st_r.a1;
    st_nxt.dir1   = pins.rd_wr;
    st_nxt.dir2   = st_r.dir1;
    if (st_r.warm != 2'h3) begin
      st_nxt.warm = st_r.warm + 2'h1;
    end
    st_nxt.rd_req = 1'b0;
    st_nxt.wr_req = 1'b0;
    unique case (mode)
      MODE_MUX_ONE: begin
        if (lo_rise) begin
          st_nxt.addr = ad_hold;                                 // [RULE_08] [RULE_12]
        end
      end
      MODE_MUX_TWO: begin
        if (hi_rise) begin
          st_nxt.addr[`BYTE_HI_MSB:`BYTE_HI_LSB] = ad_hold[`BYTE_LO_MSB:`BYTE_LO_LSB]; // [RULE_09] [RULE_11]
        end
        if (lo_rise) begin
          st_nxt.addr[`BYTE_LO_MSB:`BYTE_LO_LSB] = ad_hold[`BYTE_LO_MSB:`BYTE_LO_LSB]; // [RULE_09] [RULE_12]
        end
      end
      default: begin
        st_nxt.addr = na_addr;                                   // [RULE_06]
      end
    endcase
    if (rd_phase && !st_r.drive) begin
      st_nxt.rd_req = 1'b1;
    end
    st_nxt.drive = rd_phase;                                     // [RULE_15] [RULE_14]
    if (!sel || rd_end) begin
      st_nxt.drive = 1'b0;                                       // [RULE_15]
    end
    if (st_r.rd_req) begin
      st_nxt.rdata = rd_data;
    end
    if (wr_end) begin
      st_nxt.wr_req = 1'b1;
      st_nxt.wdata  = wide_data ? ad_s : {8'h00, ad_s[`BYTE_LO_MSB:`BYTE_LO_LSB]}; // [RULE_07] [RULE_10]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r      <= '0;
      st_r.s1   <= 6'h3F;
      st_r.s2   <= 6'h3F;
      st_r.prev <= 6'h3F;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_req   = st_r.rd_req;
  assign wr_req   = st_r.wr_req;
  assign req_addr = st_r.addr;
  assign wr_data  = st_r.wdata;
  assign pins.ad_dev_out = st_r.rdata;
  // Upper lane stays off in 8-bit width
  assign pins.ad_dev_oe  = st_r.drive ? (wide_data ? 16'hFFFF : 16'h00FF) : 16'h0000; // [RULE_07] [RULE_10] [RULE_15]
endmodule

// *** logic/host_port_host.sv ***
// Purpose: Host end of the parallel host port; runs one transfer per request
// Assumes: Requests from logic on ref_clk; pins reach a device on same clock
// Notes:   Holds each strobe phase for fixed counts
`timescale 1ns/1ps
`include "hostport_defs.svh"
module host_port_host
  import hostport_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Configuration
  input  wire logic [1:0]        addr_mode,
  input  wire logic              wide_data,
  input  wire logic              use_enable,
  input  wire logic              rd_pol_inv,
  input  wire logic              wr_pol_inv,
  input  wire logic              cs_pol_inv,
  input  wire logic              ale_pol_inv,
  // Request
  input  wire logic              req_valid,
  input  wire logic              req_read,
  input  wire logic [`ADDR_W-1:0] req_addr,
  input  wire logic [`DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [`DATA_W-1:0]     rsp_rdata,
  // Pins
  parallel_host_port_if.host     pins
);
  typedef struct packed {
    host_state_t  state;
    logic [3:0]   cnt;
    logic         read;
    logic [15:0]  addr;
    logic [15:0]  wdata;
    logic [15:0]  rdata;
    logic         rsp;
    logic         cs;
    logic         hi;
    logic         lo;
    logic         strb;
  } host_reg_t;

  host_reg_t st_r;
  host_reg_t st_nxt;
  addr_mode_t mode;
  logic [15:0] lane;
  logic [15:0] d1;
  logic [15:0] d2;
  logic        done;

  assign mode = addr_mode_t'(addr_mode);
  assign lane = wide_data ? 16'hFFFF : 16'h00FF;
  assign done = (st_r.cnt == 4'h0);

  // Pin data is asynchronous to us
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      d1 <= 16'h0000;
      d2 <= 16'h0000;
    end else begin
      d1 <= pins.ad_in;
      d2 <= d1;
    end
  end

  always_comb begin
    st_nxt     = st_r;
    st_nxt.rsp = 1'b0;
    if (!done) begin
      st_nxt.cnt = st_r.cnt - 4'h1;
    end
    unique case (st_r.state)
      H_IDLE: begin
        if (req_valid) begin
          st_nxt.read  = req_read;
          st_nxt.addr  = req_addr;
          st_nxt.wdata = req_wdata;
          st_nxt.cs    = 1'b1;
          st_nxt.cnt   = `HOST_SETUP_CYC;
          if (mode == MODE_NONMUX) begin
            // Long enough to cover the device's sync and fetch latency
            st_nxt.cnt   = `HOST_SETUP_CYC + `HOST_SETUP_CYC;
            st_nxt.state = H_DATA;
            st_nxt.strb  = 1'b1;
          end else begin
            st_nxt.state = H_ALE_A;
            st_nxt.hi    = (mode == MODE_MUX_TWO);
            st_nxt.lo    = (mode == MODE_MUX_ONE);
          end
        end
      end
      H_ALE_A: begin
        if (done) begin
          st_nxt.hi  = 1'b0;
          st_nxt.lo  = (mode == MODE_MUX_TWO);
          st_nxt.cnt = (mode == MODE_MUX_TWO) ? `HOST_SETUP_CYC : `HOST_SETUP_CYC + `HOST_SETUP_CYC;
          st_nxt.state = (mode == MODE_MUX_TWO) ? H_ALE_B : H_DATA;
          st_nxt.strb  = (mode != MODE_MUX_TWO);
          if (mode != MODE_MUX_TWO) begin
            st_nxt.lo = 1'b0;
          end
        end
      end
      H_ALE_B: begin
        if (done) begin
          st_nxt.lo    = 1'b0;
          st_nxt.strb  = 1'b1;
          st_nxt.cnt   = `HOST_SETUP_CYC + `HOST_SETUP_CYC;
          st_nxt.state = H_DATA;
        end
      end
      H_DATA: begin
        if (done) begin
          st_nxt.rdata = d2 & lane;
          st_nxt.strb  = 1'b0;
          st_nxt.cnt   = `HOST_HOLD_CYC;
          st_nxt.state = H_HOLD;
        end
      end
      H_HOLD: begin
        if (done) begin
          st_nxt.cs    = 1'b0;
          st_nxt.rsp   = st_r.read;
          st_nxt.state = H_IDLE;
        end
      end
      default: begin
        st_nxt.state = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  logic addr_phase;
  logic drive_data;
  assign addr_phase = (st_r.state == H_ALE_A) || (st_r.state == H_ALE_B);
  assign drive_data = !st_r.read && ((st_r.state == H_DATA) || (st_r.state == H_HOLD));

  assign req_ready = (st_r.state == H_IDLE);
  assign rsp_valid = st_r.rsp;
  assign rsp_rdata = st_r.rdata;
  assign pins.cs_n  = cs_pol_inv ^ ~st_r.cs;                                           // [RULE_05]
  assign pins.rd_n  = rd_pol_inv ^ ~(st_r.strb && st_r.read && !use_enable);            // [RULE_01]
  assign pins.wr_n  = wr_pol_inv ^ ~(st_r.strb && !st_r.read && !use_enable);           // [RULE_04]
  assign pins.data_phase_strobe = wr_pol_inv ^ ~(st_r.strb && use_enable);              // [RULE_03]
  assign pins.rd_wr = rd_pol_inv ^ st_r.read;                                           // [RULE_02]
  assign pins.high_addr_latch = ale_pol_inv ^ ~st_r.hi;                                 // [RULE_13]
  assign pins.low_addr_latch  = ale_pol_inv ^ ~st_r.lo;                                 // [RULE_13]
  assign pins.addr  = st_r.addr[4:0];
  // Dual phase puts each address byte on the low lane
  assign pins.ad_host_out = addr_phase
    ? ((mode == MODE_MUX_TWO) ? {8'h00, (st_r.state == H_ALE_A) ? st_r.addr[15:8] : st_r.addr[7:0]}
                              : st_r.addr)                                              // [RULE_09]
    : st_r.wdata;
  assign pins.ad_host_oe = addr_phase ? ((mode == MODE_MUX_TWO) ? 16'h00FF : 16'hFFFF)
                         : (drive_data ? lane : 16'h0000);
endmodule

// *** tb/host_port_checker.sv ***
// Purpose: Pin-level checks between host and device ends
// Assumes: Signals of parallel_host_port_if plus the shared config
// Notes:   Strobe sense follows the polarity inputs
`timescale 1ns/1ps
module host_port_checker
  import hostport_pkg::*;
(
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Configuration
  input wire logic [1:0]  addr_mode,
  input wire logic        wide_data,
  input wire logic        use_enable,
  input wire logic        rd_pol_inv,
  input wire logic        wr_pol_inv,
  input wire logic        cs_pol_inv,
  input wire logic        ale_pol_inv,
  // Pins
  input wire logic        rd_n,
  input wire logic        rd_wr,
  input wire logic        wr_n,
  input wire logic        data_phase_strobe,
  input wire logic        cs_n,
  input wire logic        high_addr_latch,
  input wire logic        low_addr_latch,
  input wire logic [15:0] ad_host_oe,
  input wire logic [15:0] ad_dev_oe
);
  logic cs_act, rd_act, wr_act, en_act, hi_act, lo_act, rd_phase;
  assign cs_act   = (cs_n == cs_pol_inv);
  assign rd_act   = (rd_n == rd_pol_inv);
  assign wr_act   = (wr_n == wr_pol_inv);
  assign en_act   = (data_phase_strobe == wr_pol_inv);
  assign hi_act   = (high_addr_latch == ale_pol_inv);
  assign lo_act   = (low_addr_latch == ale_pol_inv);
  assign rd_phase = cs_act && (rd_act || (use_enable && en_act && (rd_wr != rd_pol_inv)));

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_OE_RELEASE: assert property (!rd_phase [*6] |-> ad_dev_oe == 16'h0000)
    else $error("device drives outside a read phase");
  AST_OE_START: assert property ($rose(|ad_dev_oe) |-> rd_phase)
    else $error("device starts driving without a read phase");
  AST_NO_CONTENTION: assert property ((ad_dev_oe & ad_host_oe) == 16'h0000)
    else $error("both ends drive the same line");
  AST_UPPER_OFF: assert property (!wide_data && addr_mode != MODE_MUX_ONE |-> ad_dev_oe[15:8] == 8'h00)
    else $error("upper lines driven in 8-bit mode");
  AST_IDLE_STROBES: assert property (!cs_act |-> !rd_act && !wr_act && !en_act && !hi_act && !lo_act)
    else $error("strobe active while deselected");
  AST_RD_WR_EXCL: assert property (!(rd_act && wr_act))
    else $error("read and write strobes both active");
  AST_NONMUX_NO_ALE: assert property (addr_mode == MODE_NONMUX |-> !hi_act && !lo_act)
    else $error("address latch used in non-multiplexed mode");
  AST_SINGLE_NO_HI: assert property (addr_mode == MODE_MUX_ONE |-> !hi_act)
    else $error("high latch used in single-phase mode");

  cover property (rd_phase && ad_dev_oe != 16'h0000);
  cover property (addr_mode == MODE_MUX_TWO && hi_act);
  cover property (addr_mode == MODE_MUX_ONE && lo_act);
endmodule

// *** tb/tb_host_bus_pin_interface.sv ***
// Purpose: Host end against device end over the pin bundle
// Assumes: Pull-up on every shared line
// Notes:   Every mode and width, four polarity sets, write then read
`timescale 1ns/1ps
module tb_host_bus_pin_interface
  import hostport_pkg::*;
;
  logic        ref_clk, rst, wide_data, use_enable;
  logic        rd_pol_inv, wr_pol_inv, cs_pol_inv, ale_pol_inv;
  logic [1:0]  addr_mode;
  logic        req_valid, req_read, req_ready, rsp_valid, rd_req, wr_req;
  logic [15:0] h_addr, h_wdata, rsp_rdata, dev_addr, dev_wdata, rd_data;
  logic [15:0] cap_addr, cap_data, a, ea, mask, idx;
  logic        wr_seen;
  int          errors, checks_done;

  parallel_host_port_if parallel_host_port_if_i ();
  assign parallel_host_port_if_i.ad_in =
    (parallel_host_port_if_i.ad_host_out & parallel_host_port_if_i.ad_host_oe) |
    (parallel_host_port_if_i.ad_dev_out & parallel_host_port_if_i.ad_dev_oe) |
    ~(parallel_host_port_if_i.ad_host_oe | parallel_host_port_if_i.ad_dev_oe);

  host_port_host host_port_host_i (
    .ref_clk(ref_clk), .rst(rst), .addr_mode(addr_mode), .wide_data(wide_data), .use_enable(use_enable),
    .rd_pol_inv(rd_pol_inv), .wr_pol_inv(wr_pol_inv), .cs_pol_inv(cs_pol_inv), .ale_pol_inv(ale_pol_inv),
    .req_valid(req_valid), .req_read(req_read), .req_addr(h_addr), .req_wdata(h_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(parallel_host_port_if_i));
  host_port_device host_port_device_i (
    .ref_clk(ref_clk), .rst(rst), .addr_mode(addr_mode), .wide_data(wide_data), .use_enable(use_enable),
    .rd_pol_inv(rd_pol_inv), .wr_pol_inv(wr_pol_inv), .cs_pol_inv(cs_pol_inv), .ale_pol_inv(ale_pol_inv),
    .pins(parallel_host_port_if_i), .rd_req(rd_req), .wr_req(wr_req), .req_addr(dev_addr),
    .wr_data(dev_wdata), .rd_data(rd_data));
  host_port_checker host_port_checker_i (
    .ref_clk(ref_clk), .rst(rst), .addr_mode(addr_mode), .wide_data(wide_data), .use_enable(use_enable),
    .rd_pol_inv(rd_pol_inv), .wr_pol_inv(wr_pol_inv), .cs_pol_inv(cs_pol_inv), .ale_pol_inv(ale_pol_inv),
    .rd_n(parallel_host_port_if_i.rd_n), .rd_wr(parallel_host_port_if_i.rd_wr),
    .wr_n(parallel_host_port_if_i.wr_n), .data_phase_strobe(parallel_host_port_if_i.data_phase_strobe),
    .cs_n(parallel_host_port_if_i.cs_n), .high_addr_latch(parallel_host_port_if_i.high_addr_latch),
    .low_addr_latch(parallel_host_port_if_i.low_addr_latch),
    .ad_host_oe(parallel_host_port_if_i.ad_host_oe), .ad_dev_oe(parallel_host_port_if_i.ad_dev_oe));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Internal space: read data derived from the address
  always @(negedge ref_clk) begin
    rd_data <= dev_addr ^ 16'hC3A5;
  end

  always @(posedge ref_clk) begin
    if (rst === 1'b1 || (req_valid === 1'b1 && req_ready === 1'b1)) begin
      wr_seen <= 1'b0;
    end else if (wr_req === 1'b1) begin
      wr_seen <= 1'b1;
    end
    if (wr_req === 1'b1) begin
      cap_data <= dev_wdata;
    end
    if (wr_req === 1'b1 || rd_req === 1'b1) begin
      cap_addr <= dev_addr;
    end
  end

  task automatic final_report;
    if (errors == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic rd, input logic [15:0] ad, input logic [15:0] wd);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    req_valid = 1'b1;
    req_read  = rd;
    h_addr    = ad;
    h_wdata   = wd;
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 0;
    while ((rd ? rsp_valid : wr_seen) !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    check({15'h0000, rd ? rsp_valid : wr_seen}, 16'h0001);
    check(cap_addr, ea);
    if (rd) begin
      check(rsp_rdata, (ea ^ 16'hC3A5) & mask);
    end else begin
      check(cap_data, wd & mask);
    end
  endtask

  initial begin
    #100000;
    errors++;
    final_report;
  end

  initial begin
    rst = 1'b1;
    {addr_mode, wide_data, use_enable, rd_pol_inv, wr_pol_inv, cs_pol_inv, ale_pol_inv} = 8'h00;
    {req_valid, req_read} = 2'h0;
    {h_addr, h_wdata} = 32'h0;
    errors = 0;
    checks_done = 0;
    repeat (12) @(posedge ref_clk);
    for (int m = 0; m < 3; m++) begin
      for (int w = 0; w < 2; w++) begin
        for (int p = 0; p < 4; p++) begin
          @(negedge ref_clk);
          rst         = 1'b1;
          addr_mode   = 2'(m);
          wide_data   = w[0];
          rd_pol_inv  = p[0];
          wr_pol_inv  = p[1];
          cs_pol_inv  = p[0] ^ p[1];
          ale_pol_inv = p[1];
          use_enable  = p[1];
          repeat (2) @(negedge ref_clk);
          rst  = 1'b0;
          idx  = 16'(m * 8 + w * 4 + p);
          a    = 16'h5A3C + 16'h1357 * idx;
          mask = w[0] ? 16'hFFFF : 16'h00FF;
          ea   = (m == 0) ? {11'h000, a[4:0] & (w[0] ? 5'h1E : 5'h1F)} : a;
          xfer(1'b0, a, ~a);
          xfer(1'b1, a, 16'h0000);
        end
      end
    end
    final_report;
  end
endmodule
